// file: msrp_host_model.sv
module msrp_host_model (
    input wire logic i_mclk,
    output logic o_reset_pin_n
);
    timeunit 1ns;
    timeprecision 1ps;
    // open-drain switch: released means the pull-up wins
    initial o_reset_pin_n = 1'b1;
    // emergency use only, never part of normal traffic
    task automatic press(input int n);
        @(posedge i_mclk) #1 o_reset_pin_n = 1'b0;
        repeat (n) @(posedge i_mclk);
        #1 o_reset_pin_n = 1'b1;
    endtask : press
endmodule : msrp_host_model

// file: msrp_pkg.sv
// Function
// - at power-on emit a ready pulse shorter than 200 ms, then return low.
// - after successful power-on drive the ready output high.
// - drive the ready output low before the module powers off.
// - burst indicator low during each transmit burst, high otherwise, high at reset.
// - low time is lead plus 0.577 ms per slot plus lag.
// - repeated bursts toggle the indicator at about 216 Hz.
// - at power-up hold internal reset for a 38 ms cancellation time.
// - an undriven reset input reads as inactive high.
// - reset input low means reset active, high means inactive.
package msrp_pkg;
    localparam int unsigned CLK_MHZ = 250;
    // times in their own unit, counts derived from the clock rate
    localparam int unsigned READY_PULSE_MS = 150;
    localparam int unsigned RESET_CANCEL_MS = 38;
    localparam int unsigned SLOT_NS = 577000;
    localparam int unsigned LEAD_US = 18;
    localparam int unsigned LAG_US = 11;
    localparam int unsigned FRAME_HZ = 216;
    localparam int unsigned READY_PULSE_CYC = READY_PULSE_MS * 1000 * CLK_MHZ;
    localparam int unsigned RESET_CANCEL_CYC = RESET_CANCEL_MS * 1000 * CLK_MHZ;
    localparam int unsigned SLOT_CYC = SLOT_NS * CLK_MHZ / 1000;
    localparam int unsigned LEAD_CYC = LEAD_US * CLK_MHZ;
    localparam int unsigned LAG_CYC = LAG_US * CLK_MHZ;
    localparam int unsigned FRAME_CYC = CLK_MHZ * 1000000 / FRAME_HZ;
    localparam logic [2:0] SLOTS_RESET = 3'h1;

    typedef enum logic [2:0] {
        MSRP_CANCEL, MSRP_PULSE, MSRP_BOOT, MSRP_READY, MSRP_OFF
    } msrp_state_type;

    typedef enum logic [1:0] {
        MSRP_IDLE, MSRP_LEAD, MSRP_SLOTS, MSRP_LAG
    } msrp_burst_type;

    typedef struct packed {
        logic [1:0] rst_sync;
        msrp_state_type state;
        logic [31:0] timer;
        logic ready;
        msrp_burst_type burst;
        logic [31:0] btimer;
        logic [2:0] slots_left;
        logic [31:0] frame_cnt;
        logic tx_ind_n;
        logic core_rst_n;
    } msrp_regs_type;

    // synchroniser starts high so the pulled-up pin shows no false reset
    localparam msrp_regs_type REGS_RESET = '{
        rst_sync: 2'h3, state: MSRP_CANCEL, timer: 32'h0, ready: 1'b0, burst: MSRP_IDLE,
        btimer: 32'h0, slots_left: 3'h0, frame_cnt: 32'h0, tx_ind_n: 1'b1, core_rst_n: 1'b0
    };
endpackage : msrp_pkg

// file: msrp_status_reset.sv
module msrp_status_reset #(
    parameter int unsigned CANCEL_CYC = msrp_pkg::RESET_CANCEL_CYC,
    parameter int unsigned PULSE_CYC = msrp_pkg::READY_PULSE_CYC,
    parameter int unsigned SLOT_CYC = msrp_pkg::SLOT_CYC,
    parameter int unsigned FRAME_CYC = msrp_pkg::FRAME_CYC
) (
    input wire logic i_mclk,
    input wire logic i_nrst,
    input wire logic i_reset_pin_n,
    input wire logic i_boot_done,
    input wire logic i_power_off_req,
    input wire logic i_tx_enable,
    input wire logic [2:0] i_tx_slots,
    output logic o_module_ready_ind,
    output logic o_tx_burst_ind_n,
    output logic o_core_rst_n
);
    msrp_pkg::msrp_regs_type r_reg;
    msrp_pkg::msrp_regs_type r_next;
    logic int_rst;

    ////////////////////////////////////////////////////////////////////////
    // internal reset: power-on reset or synchronised emergency pin
    // the pad pull-up keeps an undriven pin high, so the bench drives 1 by default
    assign int_rst = r_reg.state == msrp_pkg::MSRP_CANCEL;

    always_comb begin
        r_next = r_reg;
        r_next.rst_sync = {r_reg.rst_sync[0], i_reset_pin_n};
        r_next.timer = r_reg.timer + 32'h1;
        case (r_reg.state)
            msrp_pkg::MSRP_CANCEL: begin
                r_next.ready = 1'b0;
                if (r_reg.timer >= CANCEL_CYC - 1) begin
                    r_next.state = msrp_pkg::MSRP_PULSE;
                    r_next.timer = 32'h0;
                    r_next.ready = 1'b1;
                end
            end
            msrp_pkg::MSRP_PULSE: begin
                if (r_reg.timer >= PULSE_CYC - 1) begin
                    r_next.state = msrp_pkg::MSRP_BOOT;
                    r_next.ready = 1'b0;
                end
            end
            msrp_pkg::MSRP_BOOT: begin
                if (i_boot_done) begin
                    r_next.state = msrp_pkg::MSRP_READY;
                    r_next.ready = 1'b1;
                end
            end
            msrp_pkg::MSRP_READY: begin
                if (i_power_off_req) begin
                    r_next.state = msrp_pkg::MSRP_OFF;
                    r_next.ready = 1'b0;
                end
            end
            msrp_pkg::MSRP_OFF: r_next.ready = 1'b0;
            default: r_next.state = msrp_pkg::MSRP_CANCEL;
        endcase
        if (r_reg.state != msrp_pkg::MSRP_PULSE && r_reg.state != msrp_pkg::MSRP_CANCEL) begin
            r_next.timer = r_reg.timer;
        end

        ////////////////////////////////////////////////////////////////////
        // transmit burst: one burst per frame while enabled in the ready state
        r_next.frame_cnt = (r_reg.frame_cnt >= FRAME_CYC - 1) ? 32'h0 : r_reg.frame_cnt + 32'h1;
        r_next.btimer = r_reg.btimer + 32'h1;
        case (r_reg.burst)
            msrp_pkg::MSRP_IDLE: begin
                r_next.tx_ind_n = 1'b1;
                // starts only on frame boundary, which sets the 216 Hz rate
                if (i_tx_enable && r_reg.state == msrp_pkg::MSRP_READY
                        && r_reg.frame_cnt == 32'h0) begin
                    r_next.burst = msrp_pkg::MSRP_LEAD;
                    r_next.btimer = 32'h0;
                    r_next.tx_ind_n = 1'b0;
                    r_next.slots_left = (i_tx_slots == 3'h0) ? msrp_pkg::SLOTS_RESET : i_tx_slots;
                end
            end
            msrp_pkg::MSRP_LEAD: if (r_reg.btimer >= msrp_pkg::LEAD_CYC - 1) begin
                r_next.burst = msrp_pkg::MSRP_SLOTS;
                r_next.btimer = 32'h0;
            end
            msrp_pkg::MSRP_SLOTS: if (r_reg.btimer >= SLOT_CYC - 1) begin
                r_next.btimer = 32'h0;
                r_next.slots_left = r_reg.slots_left - 3'h1;
                if (r_reg.slots_left == 3'h1) begin
                    r_next.burst = msrp_pkg::MSRP_LAG;
                end
            end
            msrp_pkg::MSRP_LAG: if (r_reg.btimer >= msrp_pkg::LAG_CYC - 1) begin
                r_next.burst = msrp_pkg::MSRP_IDLE;
                r_next.tx_ind_n = 1'b1;
            end
            default: r_next.burst = msrp_pkg::MSRP_IDLE;
        endcase

        if (!r_reg.rst_sync[1]) begin
            r_next.state = msrp_pkg::MSRP_CANCEL;
            r_next.timer = 32'h0;
            r_next.ready = 1'b0;
        end
        if (int_rst || !r_reg.rst_sync[1]) begin
            r_next.burst = msrp_pkg::MSRP_IDLE;
            r_next.tx_ind_n = 1'b1;
        end
        // registered so the core reset output carries no decode glitch
        r_next.core_rst_n = r_next.state != msrp_pkg::MSRP_CANCEL;
    end

    always_ff @(posedge i_mclk) begin
        if (!i_nrst) begin
            r_reg <= msrp_pkg::REGS_RESET;
        end else begin
            r_reg <= r_next;
        end
    end

    assign o_module_ready_ind = r_reg.ready;
    assign o_tx_burst_ind_n = r_reg.tx_ind_n;
    assign o_core_rst_n = r_reg.core_rst_n;

    ////////////////////////////////////////////////////////////////////////
    // power sequence and internal reset
    a_cancel_hold: assert property (@(posedge i_mclk) disable iff (!i_nrst)
        r_reg.state == msrp_pkg::MSRP_CANCEL && r_reg.timer < CANCEL_CYC - 1
        |=> r_reg.state == msrp_pkg::MSRP_CANCEL || !$past(r_reg.rst_sync[1]))
        else $error("internal reset released early");

    a_release_sync: assert property (@(posedge i_mclk) disable iff (!i_nrst)
        $rose(o_core_rst_n)
        |-> $past(r_reg.rst_sync[1]) && $past(r_reg.timer) == CANCEL_CYC - 1)
        else $error("internal reset released off count");

    a_rst_quiet: assert property (@(posedge i_mclk) disable iff (!i_nrst)
        int_rst
        |-> !o_module_ready_ind && o_tx_burst_ind_n && !o_core_rst_n)
        else $error("outputs active during internal reset");

    a_pin_reset: assert property (@(posedge i_mclk) disable iff (!i_nrst)
        !i_reset_pin_n ##1 !i_reset_pin_n
        |=> ##1 !o_core_rst_n)
        else $error("reset pin low not honoured");

    a_ready_pin: assert property (@(posedge i_mclk) disable iff (!i_nrst)
        !r_reg.rst_sync[1]
        |=> !o_module_ready_ind && !o_core_rst_n)
        else $error("synchronised pin low left outputs up");

    a_sync_fall: assert property (@(posedge i_mclk) disable iff (!i_nrst)
        $fell(r_reg.rst_sync[0])
        |=> !r_reg.rst_sync[1])
        else $error("pin synchroniser skipped a stage");

    // ready indicator
    a_pulse_rise: assert property (@(posedge i_mclk) disable iff (!i_nrst)
        $rose(o_module_ready_ind) && $past(r_reg.state) == msrp_pkg::MSRP_CANCEL
        |-> r_reg.state == msrp_pkg::MSRP_PULSE)
        else $error("ready pulse mis-timed");

    a_pulse_short: assert property (@(posedge i_mclk) disable iff (!i_nrst)
        r_reg.state == msrp_pkg::MSRP_PULSE
        |-> r_reg.timer < PULSE_CYC)
        else $error("ready pulse too long");

    a_pulse_end: assert property (@(posedge i_mclk) disable iff (!i_nrst)
        r_reg.state == msrp_pkg::MSRP_PULSE && r_reg.timer == PULSE_CYC - 1
        && r_reg.rst_sync[1] |=> !o_module_ready_ind)
        else $error("ready pulse did not end");

    a_boot_low: assert property (@(posedge i_mclk) disable iff (!i_nrst)
        r_reg.state == msrp_pkg::MSRP_BOOT
        |-> !o_module_ready_ind)
        else $error("ready high while booting");

    a_ready_up: assert property (@(posedge i_mclk) disable iff (!i_nrst)
        r_reg.state == msrp_pkg::MSRP_BOOT && i_boot_done && r_reg.rst_sync[1]
        |=> o_module_ready_ind)
        else $error("ready not raised after boot");

    a_ready_off: assert property (@(posedge i_mclk) disable iff (!i_nrst)
        r_reg.state == msrp_pkg::MSRP_OFF
        |-> !o_module_ready_ind)
        else $error("ready high while off");

    a_off_final: assert property (@(posedge i_mclk) disable iff (!i_nrst)
        r_reg.state == msrp_pkg::MSRP_OFF && r_reg.rst_sync[1]
        |=> r_reg.state == msrp_pkg::MSRP_OFF)
        else $error("left power-off without reset");

    // transmit burst indicator
    a_idle_high: assert property (@(posedge i_mclk) disable iff (!i_nrst)
        r_reg.burst == msrp_pkg::MSRP_IDLE
        |-> o_tx_burst_ind_n)
        else $error("indicator low with no burst");

    a_burst_low: assert property (@(posedge i_mclk) disable iff (!i_nrst)
        r_reg.burst != msrp_pkg::MSRP_IDLE
        |-> !o_tx_burst_ind_n)
        else $error("indicator high during burst");

    a_burst_start: assert property (@(posedge i_mclk) disable iff (!i_nrst)
        r_reg.burst == msrp_pkg::MSRP_IDLE && i_tx_enable && r_reg.state == msrp_pkg::MSRP_READY
        && r_reg.frame_cnt == 32'h0 && r_reg.rst_sync[1] |=> !o_tx_burst_ind_n)
        else $error("burst did not start on frame");

    a_burst_gate: assert property (@(posedge i_mclk) disable iff (!i_nrst)
        r_reg.burst == msrp_pkg::MSRP_IDLE && !(i_tx_enable && r_reg.frame_cnt == 32'h0
        && r_reg.state == msrp_pkg::MSRP_READY) |=> o_tx_burst_ind_n)
        else $error("burst started off frame or outside ready");

    a_lead_start: assert property (@(posedge i_mclk) disable iff (!i_nrst)
        $rose(r_reg.burst == msrp_pkg::MSRP_LEAD)
        |-> r_reg.btimer == 32'h0 && $past(r_reg.frame_cnt) == 32'h0)
        else $error("lead phase began off frame");

    a_lead_len: assert property (@(posedge i_mclk) disable iff (!i_nrst)
        $rose(r_reg.burst == msrp_pkg::MSRP_SLOTS)
        |-> $past(r_reg.btimer) == msrp_pkg::LEAD_CYC - 1)
        else $error("lead time wrong");

    a_slot_count: assert property (@(posedge i_mclk) disable iff (!i_nrst)
        r_reg.burst == msrp_pkg::MSRP_SLOTS && r_reg.btimer >= SLOT_CYC - 1
        && r_reg.slots_left != 3'h1 && r_reg.rst_sync[1]
        |=> r_reg.burst == msrp_pkg::MSRP_SLOTS && r_reg.slots_left == $past(r_reg.slots_left) - 3'h1)
        else $error("slot count wrong");

    a_lag_end: assert property (@(posedge i_mclk) disable iff (!i_nrst)
        r_reg.burst == msrp_pkg::MSRP_LAG && r_reg.btimer >= msrp_pkg::LAG_CYC - 1
        |=> o_tx_burst_ind_n)
        else $error("indicator low after lag");

    a_frame_wrap: assert property (@(posedge i_mclk) disable iff (!i_nrst)
        r_reg.frame_cnt >= FRAME_CYC - 1
        |=> r_reg.frame_cnt == 32'h0)
        else $error("frame counter overran");
endmodule : msrp_status_reset

// file: msrp_status_reset_test.sv
module msrp_status_reset_test;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int CANCEL = 50;
    localparam int PULSE = 20;
    localparam int SLOT = 30;
    // frame must outlast the longest burst of lead, seven slots and lag
    localparam int FRAME = 8000;
    logic clk = 1'b0, nrst = 1'b0, boot = 1'b0, poff = 1'b0, txen = 1'b0;
    logic [2:0] slots = 3'h0;
    logic ready, tx_n, core_n, pin_n;
    logic [31:0] seed = 32'h7AE0E5E4;
    int failures = 0, n_compared = 0, cyc = 0, n = 0, t0 = 0;
    msrp_status_reset #(.CANCEL_CYC(CANCEL), .PULSE_CYC(PULSE), .SLOT_CYC(SLOT),
        .FRAME_CYC(FRAME)) u_dut (.i_mclk(clk), .i_nrst(nrst), .i_reset_pin_n(pin_n),
        .i_boot_done(boot), .i_power_off_req(poff), .i_tx_enable(txen), .i_tx_slots(slots),
        .o_module_ready_ind(ready), .o_tx_burst_ind_n(tx_n), .o_core_rst_n(core_n));
    msrp_host_model u_host (.i_mclk(clk), .o_reset_pin_n(pin_n));
    ////////////////////////////////////////////////////////////////////////////
    initial forever #2 clk = ~clk;
    always @(posedge clk) cyc <= cyc + 1;
    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : xs
    // zero slots is taken as one slot
    function automatic int burst_len(input logic [2:0] s);
        return msrp_pkg::LEAD_CYC + (s == 3'h0 ? 1 : int'(s)) * SLOT + msrp_pkg::LAG_CYC;
    endfunction : burst_len
    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        n_compared++;
        if (seen !== exp) begin
            failures++;
            $display("MISMATCH t=%0t %s seen %0d exp %0d", $time, what, seen, exp);
        end
    endtask : check
    function automatic logic pick(input int s);
        return s == 0 ? core_n : (s == 1 ? ready : tx_n);
    endfunction : pick
    task automatic span(input int s, input logic lvl, input int lim);
        n = 0;
        while (pick(s) === lvl && n < lim) begin
            if (s == 0) check(32'({tx_n, ready}), 32'h2, "held outputs");
            @(posedge clk) #1 n++;
        end
    endtask : span
    task automatic await(input int s, input logic lvl, input int lim);
        repeat (lim) if (pick(s) !== lvl) @(posedge clk) #1;
        check(32'(pick(s)), 32'(lvl), "await level");
    endtask : await
    task automatic print_verdict();
        $display("compared %0d mismatches %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : print_verdict
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        #400000;
        failures++;
        print_verdict();
    end
    initial begin
        repeat (10) @(posedge clk);
        #1 nrst = 1'b1;
        span(0, 1'b0, CANCEL + 8);
        check(32'(n >= CANCEL && n <= CANCEL + 2), 32'h1, "cancel time");
        await(1, 1'b1, 4);
        span(1, 1'b1, PULSE + 8);
        check(32'(n >= PULSE - 1 && n <= PULSE + 1), 32'h1, "ready pulse");
        repeat (5) @(posedge clk) #1 check(32'(ready), 32'h0, "low after pulse");
        boot = 1'b1;
        @(posedge clk) #1 boot = 1'b0;
        await(1, 1'b1, 2);
        $display("test power-on done");
        txen = 1'b1;
        for (int i = 0; i < 4; i++) begin
            slots = i == 0 ? 3'h0 : (i == 1 ? 3'h7 : 3'(xs()));
            await(2, 1'b0, FRAME + 8);
            if (i > 0) check(32'(cyc - t0), 32'(FRAME), "burst period");
            t0 = cyc;
            span(2, 1'b0, FRAME);
            check(32'(n >= burst_len(slots) && n <= burst_len(slots) + 1), 32'h1,
                "burst low");
        end
        txen = 1'b0;
        span(2, 1'b1, FRAME + 8);
        check(32'(n), 32'(FRAME + 8), "idle high");
        $display("test bursts done");
        poff = 1'b1;
        @(posedge clk) #1 poff = 1'b0;
        await(1, 1'b0, 2);
        txen = 1'b1;
        span(2, 1'b1, FRAME + 8);
        check(32'(n), 32'(FRAME + 8), "no burst when off");
        $display("test power-off done");
        u_host.press(5);
        check(32'(core_n), 32'h0, "pin reset taken");
        span(0, 1'b0, CANCEL + 16);
        check(32'(n >= CANCEL && n <= CANCEL + 6), 32'h1, "pin reset length");
        $display("test pin reset done");
        print_verdict();
    end
endmodule : msrp_status_reset_test
